/* hdl/sisr_regs.svh */
// constants for the integrity and status response frames
`ifndef SISR_REGS_SVH
`define SISR_REGS_SVH
`define SISR_REPLY_CH14 4'hB
`define SISR_REPLY_CH58 4'hC
`define SISR_REPLY_STAT 4'hD
`define SISR_PATTERN_CH 6'h15
`define SISR_PATTERN_STAT 3'h0
`define SISR_RW_RST 1'b1
`define SISR_FRAME_RST {4'h0, `SISR_RW_RST, 27'h0}
`define SISR_CODE_TRI 3'h0
`define SISR_CODE_PFET_ON 3'h4
`define SISR_CODE_PFET_OFF 3'h2
`define SISR_CODE_PFET_BOTH 3'h6
`define SISR_CODE_NFET_OFF 3'h2
`define SISR_CODE_NFET_ON 3'h1
`define SISR_CODE_NFET_BOTH 3'h3
`define SISR_F_REPLY 31:28
`define SISR_F_RW 27
`define SISR_F_PATTERN_CH 26:21
`define SISR_F_PATTERN_STAT 26:24
`define SISR_F_FB_PROT 23
`define SISR_F_OT 22
`define SISR_F_SDO_OV 21
`define SISR_F_TEMP 20:11
`define SISR_F_BATT 10:1
`define SISR_F_SLOT_TOP 12:10
`define SISR_F_SLOT_LOW 3:1
`define SISR_F_PARITY 0
`endif

/* hdl/sisr_pkg.sv */
// types shared by the response frame logic
package sisr_pkg;
    typedef enum logic [1:0] {
        SISR_CMD_CH14 = 2'h0,
        SISR_CMD_CH58 = 2'h1,
        SISR_CMD_STAT = 2'h3
    } sisr_cmd_e;

    typedef struct packed {
        logic valid;
        sisr_cmd_e cmd;
        logic rw;
    } sisr_req_s;

    typedef struct packed {
        logic [7:0] sink_on;
        logic [7:0] source_on;
    } sisr_gate_s;

    typedef struct packed {
        logic [9:0] temp_code;
        logic [9:0] battery_voltage_code;
    } sisr_adc_s;
endpackage

/* hdl/sisr_sync.sv */
// three-flop synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ns
module sisr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] lvl_d;

    // a bit only moves once the second and third stages agree
    always_comb begin
        lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule

/* hdl/sisr_top.sv */
// builds the channel integrity and device status response frames
`timescale 1ns/1ns
`include "sisr_regs.svh"
module sisr_top (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // frame request from the serial engine, same clock
    input wire sisr_pkg::sisr_req_s i_req,
    // channel configuration, 1 marks a p-channel high side
    input wire logic [7:0] i_pfet_cfg,
    input wire logic [7:0] i_cmd_on,
    input wire sisr_pkg::sisr_adc_s i_adc,
    // asynchronous comparator levels
    input wire sisr_pkg::sisr_gate_s i_gate_source_status,
    input wire logic [7:0] i_drain_high,
    input wire logic i_feedback_pin_protect_trip,
    input wire logic i_overtemp_now,
    input wire logic i_serial_out_overvoltage,
    // response frame
    output logic [31:0] o_frame,
    output logic o_frame_valid
);
    import sisr_pkg::*;

    localparam int SYNC_W = 27;

    logic rst_a_q, rst_b_q, rst_n;
    logic [SYNC_W-1:0] sync_lvl;
    logic [7:0] sink_s, source_s, drain_s;
    logic trip_s, ot_s, sdo_ov_s;
    logic fb_flag_q, fb_flag_d, sdo_flag_q, sdo_flag_d;
    logic [31:0] frame_q, frame_d;
    logic valid_q, valid_d;
    logic [11:0] codes_lo, codes_hi;
    logic [30:0] body;
    logic stat_read;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_n = rst_b_q;

    sisr_sync #(.W(SYNC_W)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async({i_gate_source_status.sink_on, i_gate_source_status.source_on, i_drain_high,
                  i_feedback_pin_protect_trip, i_overtemp_now, i_serial_out_overvoltage}),
        .o_level(sync_lvl)
    );
    assign {sink_s, source_s, drain_s, trip_s, ot_s, sdo_ov_s} = sync_lvl;

    function automatic logic [2:0] gate_code(input logic pfet, input logic sink, input logic src);
        logic [1:0] sel;
        sel = {sink, src};
        if (pfet) begin
            case (sel)
                2'h2: gate_code = `SISR_CODE_PFET_ON;
                2'h1: gate_code = `SISR_CODE_PFET_OFF;
                2'h3: gate_code = `SISR_CODE_PFET_BOTH;
                default: gate_code = `SISR_CODE_TRI;
            endcase
        end else begin
            case (sel)
                2'h2: gate_code = `SISR_CODE_NFET_OFF;
                2'h1: gate_code = `SISR_CODE_NFET_ON;
                2'h3: gate_code = `SISR_CODE_NFET_BOTH;
                default: gate_code = `SISR_CODE_TRI;
            endcase
        end
    endfunction

    // channel packing, highest channel on top
    always_comb begin
        codes_lo = '0;
        codes_hi = '0;
        for (int i = 0; i < 4; i++) begin
            codes_lo[3*i +: 3] = gate_code(i_pfet_cfg[i], sink_s[i], source_s[i]);
            codes_hi[3*i +: 3] = gate_code(i_pfet_cfg[i+4], sink_s[i+4], source_s[i+4]);
        end
    end

    assign stat_read = i_req.valid && (i_req.cmd == SISR_CMD_STAT);

    // protect flag, a trip in the clearing cycle wins
    // serial out overvoltage flag, same set-over-clear rule
    always_comb begin
        fb_flag_d = trip_s | (fb_flag_q & ~stat_read);
        sdo_flag_d = sdo_ov_s | (sdo_flag_q & ~stat_read);
    end

    // frame assembly; unknown command codes leave the last frame in place
    always_comb begin
        body = '0;
        frame_d = frame_q;
        valid_d = 1'b0;
        if (i_req.valid) begin
            case (i_req.cmd)
                SISR_CMD_CH14: begin
                    body = {`SISR_REPLY_CH14, i_req.rw, `SISR_PATTERN_CH, drain_s[3:0], i_cmd_on[3:0], codes_lo};
                    valid_d = 1'b1;
                end
                SISR_CMD_CH58: begin
                    body = {`SISR_REPLY_CH58, i_req.rw, `SISR_PATTERN_CH, drain_s[7:4], i_cmd_on[7:4], codes_hi};
                    valid_d = 1'b1;
                end
                SISR_CMD_STAT: begin
                    body = {`SISR_REPLY_STAT, i_req.rw, `SISR_PATTERN_STAT, fb_flag_q, ot_s, sdo_flag_q,
                            i_adc.temp_code, i_adc.battery_voltage_code};
                    valid_d = 1'b1;
                end
                default: begin
                    body = '0;
                    valid_d = 1'b0;
                end
            endcase
            // one when the body holds an even count of ones
            if (valid_d) begin
                frame_d = {body, ~^body};
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= `SISR_FRAME_RST;
            valid_q <= 1'b0;
            fb_flag_q <= 1'b0;
            sdo_flag_q <= 1'b0;
        end else begin
            frame_q <= frame_d;
            valid_q <= valid_d;
            fb_flag_q <= fb_flag_d;
            sdo_flag_q <= sdo_flag_d;
        end
    end

    assign o_frame = frame_q;
    assign o_frame_valid = valid_q;

    sequence s_stat_req;
        i_req.valid && i_req.cmd == SISR_CMD_STAT;
    endsequence

    sequence s_ch14_req;
        i_req.valid && i_req.cmd == SISR_CMD_CH14;
    endsequence

    property p_parity;
        @(posedge i_core_clk) disable iff (!rst_n)
        o_frame_valid |-> (^o_frame) == 1'b1;
    endproperty
    a_parity: assert property (p_parity) else $error("frame parity wrong");

    property p_reply_code;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_ch14_req |=> o_frame_valid && o_frame[`SISR_F_REPLY] == `SISR_REPLY_CH14
            && o_frame[`SISR_F_PATTERN_CH] == `SISR_PATTERN_CH;
    endproperty
    a_reply_code: assert property (p_reply_code) else $error("reply code or marker wrong");

    property p_rw_echo;
        @(posedge i_core_clk) disable iff (!rst_n)
        i_req.valid && i_req.cmd != 2'h2 |=> o_frame[`SISR_F_RW] == $past(i_req.rw);
    endproperty
    a_rw_echo: assert property (p_rw_echo) else $error("access type bit wrong");

    property p_pfet_code;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_ch14_req ##0 (i_pfet_cfg[3] && sink_s[3] && !source_s[3])
            |=> o_frame[`SISR_F_SLOT_TOP] == `SISR_CODE_PFET_ON;
    endproperty
    a_pfet_code: assert property (p_pfet_code) else $error("p-channel code wrong in top slot");

    property p_nfet_code;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_ch14_req ##0 (!i_pfet_cfg[0] && !sink_s[0] && source_s[0])
            |=> o_frame[`SISR_F_SLOT_LOW] == `SISR_CODE_NFET_ON;
    endproperty
    a_nfet_code: assert property (p_nfet_code) else $error("n-channel code wrong in low slot");

    property p_adc_fields;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_stat_req |=> o_frame[`SISR_F_TEMP] == $past(i_adc.temp_code)
            && o_frame[`SISR_F_BATT] == $past(i_adc.battery_voltage_code);
    endproperty
    a_adc_fields: assert property (p_adc_fields) else $error("adc fields wrong");

    property p_fb_clear;
        @(posedge i_core_clk) disable iff (!rst_n)
        s_stat_req ##0 !trip_s |=> !fb_flag_q ##0 o_frame[`SISR_F_FB_PROT] == $past(fb_flag_q);
    endproperty
    a_fb_clear: assert property (p_fb_clear) else $error("protect flag not cleared on read");

    property p_fb_set;
        @(posedge i_core_clk) disable iff (!rst_n)
        trip_s |=> fb_flag_q;
    endproperty
    a_fb_set: assert property (p_fb_set) else $error("protect flag not set");

    property p_sdo_flag;
        @(posedge i_core_clk) disable iff (!rst_n)
        sdo_ov_s ##1 (s_stat_req ##0 !sdo_ov_s) |=> o_frame[`SISR_F_SDO_OV] && !sdo_flag_q;
    endproperty
    a_sdo_flag: assert property (p_sdo_flag) else $error("sdo overvoltage flag wrong");
endmodule

/* bench/sisr_master_model.sv */
// serial master model: issues frame requests and judges the answers
`timescale 1ns/1ns
module sisr_master_model (
    // clock
    input wire logic i_core_clk,
    // answer from the device
    input wire logic [31:0] i_frame,
    input wire logic i_frame_valid,
    // request to the device
    output sisr_pkg::sisr_req_s o_req
);
    import sisr_pkg::*;
    initial o_req = '0;
    // any other code means lost control
    function automatic logic code_ok(input logic pfet, input logic [2:0] code);
        return code == 3'h0 || code == 3'h2 || code == (pfet ? 3'h4 : 3'h1);
    endfunction
    task automatic xfer(input sisr_cmd_e cmd, input logic rw, output logic [31:0] f, output logic ok);
        int i;
        ok = 1'b0;
        f = 32'h0;
        @(posedge i_core_clk);
        o_req <= '{valid: 1'b1, cmd: cmd, rw: rw};
        @(posedge i_core_clk);
        o_req.valid <= 1'b0;
        for (i = 0; i < 4 && !ok; i++) begin
            @(negedge i_core_clk);
            if (i_frame_valid === 1'b1) begin
                f = i_frame;
                // whole frame holds an odd count
                ok = (^i_frame) === 1'b1;
            end
        end
    endtask
endmodule

/* bench/spi_integrity_status_responses_tb.sv */
// self-checking bench for the response frame builder
`timescale 1ns/1ns
`include "sisr_regs.svh"
module spi_integrity_status_responses_tb;
    import sisr_pkg::*;
    typedef struct packed {
        sisr_cmd_e cmd;
        logic rw;
        logic [7:0] pfet;
        logic [7:0] sink;
        logic [7:0] src;
        logic [7:0] drain;
        logic [19:0] adc;
    } sisr_row_s;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    sisr_req_s req;
    logic [7:0] pfet_cfg = 8'h00;
    logic [7:0] cmd_on = 8'h00;
    sisr_adc_s adc = '0;
    sisr_gate_s gate = '0;
    logic [7:0] drain = 8'h00;
    logic trip = 1'b0;
    logic ot = 1'b0;
    logic sdo = 1'b0;
    logic [31:0] frame;
    logic frame_valid;
    logic [31:0] f;
    logic [31:0] f_last;
    logic ok;
    int num_errors = 0;
    int samples_checked = 0;
    // commanded-on bits are derived from the drain pattern so each row needs no extra column
    localparam logic [7:0] CMD_ON_MASK = 8'hA5;
    // p-channel both-on and n-channel rows hit every code
    sisr_row_s rows [6] = '{
        '{SISR_CMD_CH14, 1'b1, 8'h0F, 8'h05, 8'h03, 8'h9C, 20'h00000},
        '{SISR_CMD_CH58, 1'b0, 8'h00, 8'h50, 8'h30, 8'h3C, 20'h00000},
        '{SISR_CMD_CH14, 1'b0, 8'h0A, 8'hFE, 8'h01, 8'h63, 20'h00000},
        '{SISR_CMD_STAT, 1'b1, 8'h00, 8'h00, 8'h00, 8'h00, 20'hFFFFF},
        '{SISR_CMD_STAT, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 20'h80001},
        '{SISR_CMD_CH58, 1'b1, 8'hF0, 8'hA0, 8'h50, 8'hFF, 20'h00000}};

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    sisr_master_model u_sisr_master_model (
        .i_core_clk(core_clk),
        .i_frame(frame),
        .i_frame_valid(frame_valid),
        .o_req(req)
    );

    sisr_top u_sisr_top (
        .i_core_clk(core_clk),
        .i_rst_n(rst_n),
        .i_req(req),
        .i_pfet_cfg(pfet_cfg),
        .i_cmd_on(cmd_on),
        .i_adc(adc),
        .i_gate_source_status(gate),
        .i_drain_high(drain),
        .i_feedback_pin_protect_trip(trip),
        .i_overtemp_now(ot),
        .i_serial_out_overvoltage(sdo),
        .o_frame(frame),
        .o_frame_valid(frame_valid)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [31:0] exp_frame(input sisr_row_s r, input logic [2:0] fl);
        logic [31:0] e;
        int c;
        int ch;
        if (r.cmd == SISR_CMD_STAT) begin
            e = {`SISR_REPLY_STAT, r.rw, 3'h0, fl, r.adc, 1'b0};
        end else begin
            e = {(r.cmd == SISR_CMD_CH14) ? `SISR_REPLY_CH14 : `SISR_REPLY_CH58, r.rw, 6'h15, 21'h0};
            for (c = 0; c < 4; c++) begin
                ch = c + ((r.cmd == SISR_CMD_CH58) ? 4 : 0);
                e[17 + c] = r.drain[ch];
                e[13 + c] = r.drain[ch] ^ CMD_ON_MASK[ch];
                e[3 * c + 1 +: 3] = r.pfet[ch] ? {r.sink[ch], r.src[ch], 1'b0} : {1'b0, r.sink[ch], r.src[ch]};
            end
        end
        e[0] = ~^e[31:1];
        return e;
    endfunction

    task automatic apply(input sisr_row_s r);
        @(posedge core_clk);
        pfet_cfg <= r.pfet;
        cmd_on <= r.drain ^ CMD_ON_MASK;
        gate <= '{sink_on: r.sink, source_on: r.src};
        drain <= r.drain;
        adc <= sisr_adc_s'(r.adc);
        repeat (8) @(posedge core_clk);
    endtask

    task automatic rd(input sisr_row_s r, input logic [2:0] fl);
        u_sisr_master_model.xfer(r.cmd, r.rw, f, ok);
        check({31'h0, ok}, 32'h1, "answer missing or bad parity");
        if (ok !== 1'b1) begin
            end_of_test();
        end
        check(f, exp_frame(r, fl), "frame");
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        check({frame_valid, frame[30:0]}, 32'h0800_0000, "frame during reset");
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apply(rows[i]);
            rd(rows[i], 3'h0);
        end
        apply(rows[0]);
        rd(rows[0], 3'h0);
        check({31'h0, u_sisr_master_model.code_ok(1'b1, f[3:1])}, 32'h0, "both-on code");
        // flags latch a pulse that has already gone away
        apply(rows[3]);
        trip <= 1'b1;
        sdo <= 1'b1;
        ot <= 1'b1;
        repeat (8) @(posedge core_clk);
        trip <= 1'b0;
        sdo <= 1'b0;
        // read lands on the first cycle the filtered levels are low, so the clear meets no set
        repeat (3) @(posedge core_clk);
        rd(rows[3], 3'h7);
        rd(rows[3], 3'h2);
        f_last = f;
        u_sisr_master_model.xfer(sisr_cmd_e'(2'h2), 1'b1, f, ok);
        check({31'h0, ok}, 32'h0, "unused command answered");
        check(frame, f_last, "frame moved on unused command");
        // second reset in mid-run
        @(posedge core_clk);
        rst_n <= 1'b0;
        ot <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(frame, 32'h0800_0000, "frame after reset");
        rst_n <= 1'b1;
        apply(rows[4]);
        rd(rows[4], 3'h0);
        end_of_test();
    end
endmodule
